// ===== ddc_port.sv
// Overview of operation
// RQ1: shift din on each sclk fall, sync low
// RQ2: execute command on the 32nd fall
// RQ3: host raises sync before next frame
// RQ4: host may park sync low when idle
// RQ5: frame: 4 ignored, command, address, data
// RQ6: code is 12/14/16 bits, rest ignored
// RQ7: command 0 loads input register only
// RQ8: command 1 copies input to dac register
// RQ9: command 2 writes input, updates all channels
// RQ10: command 3 writes input and dac together
// RQ11: command 4 sets channel power modes
// RQ12: commands 5/6 load clear code, load mask
// RQ13: command 7 returns to power-on state
// RQ14: command 8 loads chain enable
// RQ15: command 9 sets aux io direction, value
// RQ16: address 0 a, 1 b, f both
// RQ17: early sync rise aborts the frame
// RQ18: abort clears shifter, nothing changes
// RQ19: code is unsigned straight binary
// RQ20: top four bits drive fifteen segments
// RQ21: low twelve bits drive the ladder
// RQ22: sync fall starts a new frame
// RQ23: unknown command or address changes nothing
// RQ24: all-channels address hits both channels
`timescale 1ns/100ps
`default_nettype none
module ddc_port #(
  parameter int unsigned      RES      = 16,
  parameter logic [RES-1:0]   POR_CODE = '0
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sync_n,
  input  wire logic                        sclk,
  input  wire logic                        din,
  output logic      [RES-1:0]              dac_code_a,
  output logic      [RES-1:0]              dac_code_b,
  output logic      [ddc_pkg::SEGS-1:0]    seg_a,
  output logic      [ddc_pkg::SEGS-1:0]    seg_b,
  output logic      [ddc_pkg::LADDER-1:0]  ladder_a,
  output logic      [ddc_pkg::LADDER-1:0]  ladder_b,
  output logic      [1:0]                  pd_mode_a,
  output logic      [1:0]                  pd_mode_b,
  output logic      [1:0]                  clear_code,
  output logic      [1:0]                  load_mask,
  output logic                             chain_enable,
  output logic                             aux_digital_io_o,
  output logic                             aux_digital_io_oe_n
);

  if (RES != 12 && RES != 14 && RES != 16) begin : g_bad_res
    $error("RES must be 12, 14 or 16");
  end

  typedef struct packed {
    logic [2:0]                  sy;
    logic [2:0]                  sc;
    logic [1:0]                  di;
    logic                        active;
    logic [5:0]                  cnt;
    logic [31:0]                 sr;
    logic                        exec;
    logic [RES-1:0]              in_a;
    logic [RES-1:0]              in_b;
    logic [RES-1:0]              dac_a;
    logic [RES-1:0]              dac_b;
    logic [1:0]                  pd_a;
    logic [1:0]                  pd_b;
    logic [1:0]                  clr;
    logic [1:0]                  ldm;
    logic                        chain;
    logic                        aux_oe_n;
    logic                        aux_val;
    logic                        ctrl_en;
    logic [7:0]                  n_done;
    logic [7:0]                  n_abort;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [ddc_pkg::LADDER-1:0]  lad_a;
    logic [ddc_pkg::LADDER-1:0]  lad_b;
  } ddc_state_s;

  ddc_state_s s;
  ddc_state_s next_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] ch_sel(input logic [3:0] a);
    logic [1:0] m;
    m = 2'h0;
    unique case (a)
      ddc_pkg::ADDR_A:   m = 2'h1;
      ddc_pkg::ADDR_B:   m = 2'h2;
      ddc_pkg::ADDR_ALL: m = 2'h3;
      default:           m = 2'h0;
    endcase
    return m;
  endfunction : ch_sel

  // narrower codes are left aligned so the core split stays fixed
  function automatic logic [ddc_pkg::FULL_RES-1:0] code16(input logic [RES-1:0] c);
    logic [ddc_pkg::FULL_RES-1:0] w;
    w = ddc_pkg::FULL_RES'(c) << (ddc_pkg::FULL_RES - RES);
    return w;
  endfunction : code16

  logic                         sync_fall;
  logic                         sync_rise;
  logic                         sclk_fall;
  logic [3:0]                   f_cmd;
  logic [3:0]                   f_addr;
  logic [RES-1:0]               f_data;
  logic [1:0]                   f_sel;
  logic [ddc_pkg::FULL_RES-1:0] c16_a;
  logic [ddc_pkg::FULL_RES-1:0] c16_b;
  logic [RES-1:0]               new_in_a;
  logic [RES-1:0]               new_in_b;

  // second stage and its copy only; first stage feeds nothing else
  assign sync_fall = s.sy[2] & ~s.sy[1];
  assign sync_rise = ~s.sy[2] & s.sy[1];
  assign sclk_fall = s.sc[2] & ~s.sc[1];
  assign f_cmd     = s.sr[ddc_pkg::CMD_MSB -: ddc_pkg::FIELD_W];   // RQ5
  assign f_addr    = s.sr[ddc_pkg::ADDR_MSB -: ddc_pkg::FIELD_W];
  assign f_data    = s.sr[ddc_pkg::DATA_MSB -: RES];               // RQ6
  assign f_sel     = ch_sel(f_addr);                               // RQ16
  assign c16_a     = code16(s.dac_a);                              // RQ19
  assign c16_b     = code16(s.dac_b);
  assign new_in_a  = f_sel[0] ? f_data : s.in_a;                   // RQ24
  assign new_in_b  = f_sel[1] ? f_data : s.in_b;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.sy    = {s.sy[1:0], sync_n};
    next_s.sc    = {s.sc[1:0], sclk};
    next_s.di    = {s.di[0], din};
    next_s.lad_a = c16_a[ddc_pkg::LADDER-1:0];                    // RQ21
    next_s.lad_b = c16_b[ddc_pkg::LADDER-1:0];                    // RQ21

    // frame capture
    if (sync_fall && s.ctrl_en) begin
      next_s.active = 1'b1;                                        // RQ22
      next_s.cnt    = '0;
      next_s.sr     = '0;
    end else if (s.active && sync_rise) begin
      next_s.active  = 1'b0;                                       // RQ17
      next_s.sr      = '0;                                         // RQ18
      next_s.n_abort = s.n_abort + 8'h01;
    end else if (s.active && sclk_fall && !s.sy[1]) begin
      next_s.sr  = {s.sr[30:0], s.di[1]};                          // RQ1
      next_s.cnt = s.cnt + 6'h01;
      if (s.cnt == ddc_pkg::LAST_BIT) begin
        next_s.active = 1'b0;                                      // RQ2
        next_s.exec   = 1'b1;                                      // RQ2
      end
    end

    // command execution, one cycle after the last bit
    if (s.exec) begin
      next_s.exec   = 1'b0;
      next_s.n_done = s.n_done + 8'h01;
    end
    // reserved address: frame counted, nothing else moves
    if (s.exec && f_sel != 2'h0) begin                             // RQ23
      case (f_cmd)
        ddc_pkg::CMD_WRITE_IN: begin
          next_s.in_a = new_in_a;                                  // RQ7
          next_s.in_b = new_in_b;
        end
        ddc_pkg::CMD_UPDATE: begin
          if (f_sel[0]) begin
            next_s.dac_a = s.in_a;                                 // RQ8
          end
          if (f_sel[1]) begin
            next_s.dac_b = s.in_b;
          end
        end
        ddc_pkg::CMD_WRITE_ALL: begin
          if (f_sel != 2'h0) begin
            next_s.in_a  = new_in_a;                               // RQ9
            next_s.in_b  = new_in_b;
            next_s.dac_a = new_in_a;
            next_s.dac_b = new_in_b;
          end
        end
        ddc_pkg::CMD_WRITE_UPD: begin
          next_s.in_a = new_in_a;                                  // RQ10
          next_s.in_b = new_in_b;
          if (f_sel[0]) begin
            next_s.dac_a = f_data;
          end
          if (f_sel[1]) begin
            next_s.dac_b = f_data;
          end
        end
        ddc_pkg::CMD_POWER: begin
          if (s.sr[ddc_pkg::CHSEL_LSB]) begin
            next_s.pd_a = s.sr[ddc_pkg::PD_MODE_LSB +: 2];         // RQ11
          end
          if (s.sr[ddc_pkg::CHSEL_LSB + 1]) begin
            next_s.pd_b = s.sr[ddc_pkg::PD_MODE_LSB +: 2];
          end
        end
        ddc_pkg::CMD_CLEAR: begin
          next_s.clr = s.sr[ddc_pkg::CHSEL_LSB +: 2];              // RQ12
        end
        ddc_pkg::CMD_LOADMASK: begin
          next_s.ldm = s.sr[ddc_pkg::CHSEL_LSB +: 2];              // RQ12
        end
        ddc_pkg::CMD_RESET: begin
          next_s.in_a    = POR_CODE;                               // RQ13
          next_s.in_b    = POR_CODE;
          next_s.dac_a   = POR_CODE;
          next_s.dac_b   = POR_CODE;
          next_s.pd_a    = '0;
          next_s.pd_b    = '0;
          next_s.clr     = '0;
          next_s.ldm     = '0;
          next_s.chain   = 1'b0;
          next_s.aux_oe_n = 1'b1;
          next_s.aux_val = 1'b0;
        end
        ddc_pkg::CMD_CHAIN: begin
          next_s.chain = s.sr[ddc_pkg::CHAIN_BIT];                 // RQ14
        end
        ddc_pkg::CMD_AUX: begin
          next_s.aux_oe_n = ~s.sr[ddc_pkg::AUX_DIR_BIT];           // RQ15
          next_s.aux_val = s.sr[ddc_pkg::AUX_VAL_BIT];
        end
        default: begin
          next_s.exec = 1'b0;                                      // RQ23
        end
      endcase
    end

    // apb slave: answer prepared in setup, given in the access cycle
    next_s.pready  = psel && !penable;
    next_s.pslverr = 1'b0;
    if (psel && !penable) begin
      next_s.prdata = '0;
      unique case (paddr)
        ddc_pkg::OFS_CTRL:   next_s.prdata = {31'h0, s.ctrl_en};
        ddc_pkg::OFS_STATUS: next_s.prdata = {s.n_abort, s.n_done, 8'h0, s.cnt, s.exec, s.active};
        ddc_pkg::OFS_IN_A:   next_s.prdata = 32'(s.in_a);
        ddc_pkg::OFS_IN_B:   next_s.prdata = 32'(s.in_b);
        ddc_pkg::OFS_DAC_A:  next_s.prdata = 32'(s.dac_a);
        ddc_pkg::OFS_DAC_B:  next_s.prdata = 32'(s.dac_b);
        ddc_pkg::OFS_MODE:   next_s.prdata = {20'h0, s.ldm, s.clr, 1'b0, s.aux_val,
                                              ~s.aux_oe_n, s.chain, s.pd_b, s.pd_a};
        default:             next_s.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite && paddr == ddc_pkg::OFS_CTRL) begin
      next_s.ctrl_en = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.sy      <= 3'h7;
      s.sc      <= 3'h7;
      s.in_a    <= POR_CODE;
      s.in_b    <= POR_CODE;
      s.dac_a   <= POR_CODE;
      s.dac_b   <= POR_CODE;
      s.ctrl_en <= ddc_pkg::CTRL_RESET;
      s.aux_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // segment decoders
  // ---------------------------------------------------------------
  ddc_thermo u_seg_a (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (c16_a[ddc_pkg::FULL_RES-1 -: ddc_pkg::SEG_BITS]),
    .segs    (seg_a)
  );

  ddc_thermo u_seg_b (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (c16_b[ddc_pkg::FULL_RES-1 -: ddc_pkg::SEG_BITS]),
    .segs    (seg_b)
  );

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign dac_code_a          = s.dac_a;
  assign dac_code_b          = s.dac_b;
  assign ladder_a            = s.lad_a;
  assign ladder_b            = s.lad_b;
  assign pd_mode_a           = s.pd_a;
  assign pd_mode_b           = s.pd_b;
  assign clear_code          = s.clr;
  assign load_mask           = s.ldm;
  assign chain_enable        = s.chain;
  assign aux_digital_io_o    = s.aux_val;
  assign aux_digital_io_oe_n = s.aux_oe_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_shift_bit: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (s.active && sclk_fall && !s.sy[1] && !sync_fall && !sync_rise)
    |=> s.sr == {$past(s.sr[30:0]), $past(s.di[1])})
    else $error("shift register did not take the data bit");

  a_last_exec: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (s.active && sclk_fall && !s.sy[1] && !sync_rise && !sync_fall &&
     s.cnt == ddc_pkg::LAST_BIT) |=> (s.exec && !s.active) ##1 !s.exec)
    else $error("frame not executed on the last falling edge");

  a_abort_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    (s.active && sync_rise && !sync_fall) |=> (s.sr == '0 && !s.active && !s.exec))
    else $error("aborted frame left data behind");

  a_frame_start: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
    (sync_fall && s.ctrl_en) |=> (s.active && s.cnt == '0))
    else $error("sync fall did not start a frame");

  a_write_input: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (s.exec && f_cmd == ddc_pkg::CMD_WRITE_IN && f_addr == ddc_pkg::ADDR_A)
    |=> (s.in_a == $past(f_data) && $stable(s.dac_a)))
    else $error("input write touched the wrong register");

  a_update_dac: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    (s.exec && f_cmd == ddc_pkg::CMD_UPDATE && f_addr == ddc_pkg::ADDR_A)
    |=> s.dac_a == $past(s.in_a))
    else $error("update did not copy input register");

  a_both_direct: assert property (@(posedge pclk) disable iff (!presetn) // RQ24
    (s.exec && f_cmd == ddc_pkg::CMD_WRITE_UPD && f_addr == ddc_pkg::ADDR_ALL)
    |=> (s.dac_a == $past(f_data) && s.dac_b == $past(f_data)))
    else $error("all-channels write missed a channel");

  a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    (s.exec && f_cmd == ddc_pkg::CMD_RESET && f_sel != 2'h0)
    |=> (s.dac_a == POR_CODE && s.in_b == POR_CODE && s.pd_a == '0 && !s.chain))
    else $error("software reset incomplete");

  a_reserved_addr: assert property (@(posedge pclk) disable iff (!presetn) // RQ23
    (s.exec && f_sel == 2'h0 && f_cmd <= ddc_pkg::CMD_WRITE_UPD)
    |=> ($stable(s.in_a) && $stable(s.in_b) && $stable(s.dac_a) && $stable(s.dac_b)))
    else $error("reserved address changed a register");

  a_ladder_bits: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    ##1 ladder_a == $past(c16_a[ddc_pkg::LADDER-1:0]))
    else $error("ladder does not follow the code");

endmodule : ddc_port
`default_nettype wire

// ===== ddc_pkg.sv
package ddc_pkg;

  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned FIELD_W     = 4;
  localparam int unsigned CMD_MSB     = 27;
  localparam int unsigned ADDR_MSB    = 23;
  localparam int unsigned DATA_MSB    = 19;
  localparam int unsigned PD_MODE_LSB = 8;
  localparam int unsigned CHSEL_LSB   = 0;
  localparam int unsigned CHAIN_BIT   = 1;
  localparam int unsigned AUX_DIR_BIT = 1;
  localparam int unsigned AUX_VAL_BIT = 0;
  localparam logic [5:0]  LAST_BIT    = 6'h1F;

  // ---------------------------------------------------------------
  // commands and channel addresses
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_WRITE_IN  = 4'h0;
  localparam logic [3:0] CMD_UPDATE    = 4'h1;
  localparam logic [3:0] CMD_WRITE_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER     = 4'h4;
  localparam logic [3:0] CMD_CLEAR     = 4'h5;
  localparam logic [3:0] CMD_LOADMASK  = 4'h6;
  localparam logic [3:0] CMD_RESET     = 4'h7;
  localparam logic [3:0] CMD_CHAIN     = 4'h8;
  localparam logic [3:0] CMD_AUX       = 4'h9;
  localparam logic [3:0] ADDR_A        = 4'h0;
  localparam logic [3:0] ADDR_B        = 4'h1;
  localparam logic [3:0] ADDR_ALL      = 4'hF;

  // ---------------------------------------------------------------
  // converter core split
  // ---------------------------------------------------------------
  localparam int unsigned FULL_RES = 16;
  localparam int unsigned SEG_BITS = 4;
  localparam int unsigned SEGS     = 15;
  localparam int unsigned LADDER   = 12;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IN_A   = 8'h08;
  localparam logic [7:0] OFS_IN_B   = 8'h0C;
  localparam logic [7:0] OFS_DAC_A  = 8'h10;
  localparam logic [7:0] OFS_DAC_B  = 8'h14;
  localparam logic [7:0] OFS_MODE   = 8'h18;
  localparam logic       CTRL_RESET = 1'h1;

endpackage : ddc_pkg

// ===== ddc_thermo.sv
`timescale 1ns/100ps
`default_nettype none
module ddc_thermo (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [ddc_pkg::SEG_BITS-1:0] code,
  output logic      [ddc_pkg::SEGS-1:0]     segs
);

  typedef struct packed {
    logic [ddc_pkg::SEGS-1:0] segs;
  } ddc_thermo_s;

  ddc_thermo_s s;
  ddc_thermo_s next_s;

  // ---------------------------------------------------------------
  // thermometer decode
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    for (int i = 0; i < ddc_pkg::SEGS; i++) begin
      next_s.segs[i] = (code > i[ddc_pkg::SEG_BITS-1:0]); // RQ20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign segs = s.segs;

endmodule : ddc_thermo
`default_nettype wire

// ===== ddc_dummy_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== ddc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ddc_host_model (
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic [31:0] frame,
  input  wire logic [5:0]  nbits,
  input  wire logic [3:0]  half,
  input  wire logic        park,
  output logic             sync_n,
  output logic             sclk,
  output logic             din,
  output logic             busy
);
  // ---------------------------------------------------------
  // serial master, clock stands high outside frames
  // ---------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n

  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    din    = 1'b0;
    busy   = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        if (!sync_n) begin
          sync_n <= 1'b1;
          wait_n(4);
        end
        sync_n <= 1'b0;
        wait_n(half);
        for (int i = 0; i < nbits; i++) begin
          din <= frame[5'(31 - i)];
          wait_n(half);
          sclk <= 1'b0;
          wait_n(half);
          sclk <= 1'b1;
        end
        wait_n(half);
        if (!park) sync_n <= 1'b1;
        wait_n(4);
        busy <= 1'b0;
      end else if (sync_n) begin
        din <= ~din;  // deselected line must not look stable
      end
    end
  end
endmodule : ddc_host_model
`default_nettype wire

// ===== dual_dac_serial_command_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_command_port_bench;
  typedef struct packed {
    logic [15:0] in_a, in_b, dac_a, dac_b;
    logic [1:0]  pd_a, pd_b, clr, mask;
    logic        chain, dir, val;
  } ddc_exp_s;
  ddc_exp_s    e;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, f, frame;
  logic        sync_n, sclk, din, busy, go, park, ctrl_en;
  logic [5:0]  nbits;
  logic [3:0]  half;
  logic [15:0] dac_code_a, dac_code_b;
  logic [14:0] seg_a, seg_b;
  logic [11:0] ladder_a, ladder_b;
  logic [1:0]  pd_mode_a, pd_mode_b, clear_code, load_mask;
  logic        chain_enable, aux_digital_io_o, aux_digital_io_oe_n;
  int          n_fail, checked, n_exec, n_abort;
  logic [31:0] tab [17] = '{32'hF00BEEF7, 32'h01000000, 32'h03112345, 32'h02080019,
    32'h00F0FFFC, 32'h01F00000, 32'h53FFFFFF, 32'h04000201, 32'h04000302, 32'h05000002,
    32'h06000003, 32'h08000002, 32'h09000003, 32'h03212345, 32'h0F0FFFF0, 32'h07000000,
    32'h030A5A50};

  ddc_port #(.RES(16), .POR_CODE(16'h0000)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_n(sync_n), .sclk(sclk), .din(din), .dac_code_a(dac_code_a),
    .dac_code_b(dac_code_b), .seg_a(seg_a), .seg_b(seg_b), .ladder_a(ladder_a),
    .ladder_b(ladder_b), .pd_mode_a(pd_mode_a), .pd_mode_b(pd_mode_b),
    .clear_code(clear_code), .load_mask(load_mask), .chain_enable(chain_enable),
    .aux_digital_io_o(aux_digital_io_o), .aux_digital_io_oe_n(aux_digital_io_oe_n));
  ddc_host_model i_host (.pclk(pclk), .go(go), .frame(frame), .nbits(nbits), .half(half),
    .park(park), .sync_n(sync_n), .sclk(sclk), .din(din), .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ---------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [14:0] thermo(input logic [15:0] c);
    logic [15:0] t;
    t = (16'h1 << c[15:12]) - 16'h1;
    return t[14:0];
  endfunction : thermo

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_bit(input string nm, input logic x, input logic g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, x, g);
    end
  endtask : chk_bit

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_bit("apb_ready", 1'b1, pready);
  endtask : apb

  task automatic apply(input logic [31:0] fr);
    logic ha;
    logic hb;
    logic [15:0] d;
    ha = fr[23:20] inside {ddc_pkg::ADDR_A, ddc_pkg::ADDR_ALL};
    hb = fr[23:20] inside {ddc_pkg::ADDR_B, ddc_pkg::ADDR_ALL};
    d = fr[19:4];
    n_exec++;
    if (!(ha || hb)) return;
    case (fr[27:24])
      ddc_pkg::CMD_WRITE_IN: begin
        if (ha) e.in_a = d;
        if (hb) e.in_b = d;
      end
      ddc_pkg::CMD_UPDATE: begin
        if (ha) e.dac_a = e.in_a;
        if (hb) e.dac_b = e.in_b;
      end
      ddc_pkg::CMD_WRITE_ALL: begin
        if (ha) e.in_a = d;
        if (hb) e.in_b = d;
        e.dac_a = e.in_a;
        e.dac_b = e.in_b;
      end
      ddc_pkg::CMD_WRITE_UPD: begin
        if (ha) e.in_a = d;
        if (ha) e.dac_a = d;
        if (hb) e.in_b = d;
        if (hb) e.dac_b = d;
      end
      ddc_pkg::CMD_POWER: begin
        if (fr[0]) e.pd_a = fr[9:8];
        if (fr[1]) e.pd_b = fr[9:8];
      end
      ddc_pkg::CMD_CLEAR: e.clr = fr[1:0];
      ddc_pkg::CMD_LOADMASK: e.mask = fr[1:0];
      ddc_pkg::CMD_RESET: e = '0;
      ddc_pkg::CMD_CHAIN: e.chain = fr[1];
      ddc_pkg::CMD_AUX: {e.dir, e.val} = fr[1:0];
      default: ;
    endcase
  endtask : apply

  task automatic send(input logic [31:0] fr, input logic [5:0] n);
    int w;
    w = 0;
    @(posedge pclk);
    frame <= fr;
    nbits <= n;
    go <= 1'b1;
    while (busy !== 1'b1 && w < 50) begin
      @(posedge pclk);
      w++;
    end
    chk_bit("host_start", 1'b1, busy);
    go <= 1'b0;
    while (busy !== 1'b0 && w < 3000) begin
      @(posedge pclk);
      w++;
    end
    chk_bit("host_done", 1'b0, busy);
    repeat (2) @(posedge pclk);
    if (ctrl_en && n >= 6'd32) apply(fr);
    else if (ctrl_en) n_abort++;
  endtask : send

  task automatic check_all();
    chk("dac_code_a", 32'(e.dac_a), 32'(dac_code_a));
    chk("dac_code_b", 32'(e.dac_b), 32'(dac_code_b));
    chk("seg_a", 32'(thermo(e.dac_a)), 32'(seg_a));
    chk("seg_b", 32'(thermo(e.dac_b)), 32'(seg_b));
    chk("ladder_a", 32'(e.dac_a[11:0]), 32'(ladder_a));
    chk("ladder_b", 32'(e.dac_b[11:0]), 32'(ladder_b));
    chk("pd_modes", 32'({e.pd_b, e.pd_a}), 32'({pd_mode_b, pd_mode_a}));
    chk("clear_mask", 32'({e.clr, e.mask}), 32'({clear_code, load_mask}));
    chk_bit("chain_enable", e.chain, chain_enable);
    chk_bit("aux_oe_n", ~e.dir, aux_digital_io_oe_n);
    chk_bit("aux_value", e.val, aux_digital_io_o);
    apb(1'b0, ddc_pkg::OFS_IN_A, 32'h0);
    chk("in_a", 32'(e.in_a), rd);
    apb(1'b0, ddc_pkg::OFS_IN_B, 32'h0);
    chk("in_b", 32'(e.in_b), rd);
    apb(1'b0, ddc_pkg::OFS_MODE, 32'h0);
    chk("mode_reg", {20'h0, e.mask, e.clr, 1'b0, e.val, e.dir, e.chain, e.pd_b, e.pd_a},
        rd);
  endtask : check_all

  // watchdog: about 50 frames of some 300 cycles each fit well inside
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, go, park} = 6'h00;
    {paddr, pwdata, frame} = '0;
    nbits = 6'd32;
    half = 4'h4;
    seed = 32'hE2AE9129;
    e = '0;
    ctrl_en = 1'b1;
    {n_fail, checked, n_exec, n_abort} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check_all();
    apb(1'b0, ddc_pkg::OFS_CTRL, 32'h0);
    chk_bit("ctrl_enable_reset", 1'b1, rd[0]);
    $display("test reset_values done");
    foreach (tab[i]) begin
      send(tab[i], 6'd32);
      check_all();
    end
    $display("test directed_commands done");
    send(32'h03F12340, 6'd20);
    check_all();
    send(32'h03F0FFF0, 6'd31);
    check_all();
    send(32'h0300C3C0, 6'd32);
    send(32'h0310F0F0, 6'd34);
    check_all();
    $display("test abort_and_overrun done");
    park <= 1'b1;
    send(32'h0300AAA0, 6'd32);
    send(32'h03105550, 6'd32);
    park <= 1'b0;
    send(32'h01F00000, 6'd32);
    check_all();
    $display("test parked_sync done");
    apb(1'b1, ddc_pkg::OFS_CTRL, 32'h0);
    ctrl_en = 1'b0;
    send(32'h03F07770, 6'd32);
    check_all();
    apb(1'b1, ddc_pkg::OFS_CTRL, 32'h1);
    ctrl_en = 1'b1;
    apb(1'b1, ddc_pkg::OFS_DAC_A, 32'hFFFF);
    chk_bit("ro_write_err", 1'b0, err);
    apb(1'b0, 8'h40, 32'h0);
    chk_bit("unmapped_err", 1'b1, err);
    check_all();
    $display("test register_access done");
    repeat (24) begin
      seed = xs(seed);
      f = seed;
      case (seed[6:4])
        3'd0: f[23:20] = ddc_pkg::ADDR_A;
        3'd1: f[23:20] = ddc_pkg::ADDR_B;
        3'd2, 3'd3: f[23:20] = ddc_pkg::ADDR_ALL;
        default: ;
      endcase
      f[27] = seed[9] & seed[10];
      half <= 4'(3 + seed[8:7]);
      send(f, (seed[15:12] == 4'h0) ? 6'(seed[20:16]) + 6'd1 : 6'd32);
      check_all();
    end
    $display("test random_frames done");
    apb(1'b0, ddc_pkg::OFS_STATUS, 32'h0);
    chk("status_counts", {16'h0, 8'(n_abort), 8'(n_exec)}, {16'h0, rd[31:16]});
    tally_and_finish();
  end
endmodule : dual_dac_serial_command_port_bench
`default_nettype wire
